/* rtl/ecp_defs.svh */
// What this block does
// R01: Trigger rising edge starts one measurement
// R02: Contact-check edge runs check, reports pass
// R03: Voltage-check edge starts voltage error check
// R04: Open-correction edge runs correction, reports pass
// R05: Start edge turns measurement voltage on
// R06: Stop edge turns measurement voltage off
// R07: Clear edge erases measured value and judgment
// R08: Interlock held on disables interlock protection
// R09: Panel-lock level locks keys, off releases
// R10: Done and acquisition-done on after power-up
// R11: Controller reads pass and fail together
// R12: High, within, low judgments held levels
// R13: Voltage-check pass held as level
// R14: Done after judgment; acquisition-done after conversion
// R15: Fault on overflow or capacitance over limit; if one write ends contact check and open correction, only the latter sets it
// R16: Pass when within, else fail, normal end
// R17: Sink mode inverts output pin polarity
// R18: Synchronise inputs, detect edges from samples
`ifndef ECP_DEFS_SVH
`define ECP_DEFS_SVH

// Register byte offsets
`define ECP_OFS_CTRL 8'h00
`define ECP_OFS_STATUS 8'h04
`define ECP_OFS_EVENT 8'h08
`define ECP_OFS_MASK 8'h0c
`define ECP_OFS_ACQ 8'h10
`define ECP_OFS_MEAS 8'h14
`define ECP_OFS_CHECK 8'h18
`define ECP_OFS_PINS 8'h1c

// Control fields
`define ECP_CTRL_SINK 0
`define ECP_CTRL_RESET 1'h0

// Event bits (event and mask registers share this layout)
`define ECP_EVT_WIDTH 7
`define ECP_EVT_MEASURE 0
`define ECP_EVT_CCHK 1
`define ECP_EVT_VCHK 2
`define ECP_EVT_OPEN 3
`define ECP_EVT_START 4
`define ECP_EVT_STOP 5
`define ECP_EVT_CLEAR 6
`define ECP_MASK_RESET 7'h00

// Command input vector positions
`define ECP_IN_WIDTH 9
`define ECP_IN_INTERLOCK 7
`define ECP_IN_PANEL 8

// Measurement result write fields
`define ECP_MEAS_JUDGE_LSB 0
`define ECP_MEAS_JUDGE_MSB 1
`define ECP_MEAS_OVERFLOW 2
`define ECP_JUDGE_HIGH 2'h1
`define ECP_JUDGE_IN 2'h2
`define ECP_JUDGE_LOW 2'h3

// Check result write fields
`define ECP_CHK_CC_DONE 0
`define ECP_CHK_CC_PASS 1
`define ECP_CHK_CC_OVER 2
`define ECP_CHK_OP_DONE 3
`define ECP_CHK_OP_PASS 4
`define ECP_CHK_OP_OVER 5
`define ECP_CHK_VC_DONE 6
`define ECP_CHK_VC_PASS 7

// Status fields
`define ECP_ST_INTERLOCK 0
`define ECP_ST_PANEL 1
`define ECP_ST_MEAS_BUSY 2
`define ECP_ST_CC_BUSY 3
`define ECP_ST_VC_BUSY 4
`define ECP_ST_OP_BUSY 5
`define ECP_ST_VALID 6

// Output pin vector positions
`define ECP_PIN_WIDTH 12
`define ECP_PIN_DONE 0
`define ECP_PIN_ACQ 1
`define ECP_PIN_FAULT 2
`define ECP_PIN_CCPASS 3
`define ECP_PIN_VCPASS 4
`define ECP_PIN_OPPASS 5
`define ECP_PIN_VACT 6
`define ECP_PIN_HIGH 7
`define ECP_PIN_IN 8
`define ECP_PIN_LOW 9
`define ECP_PIN_PASS 10
`define ECP_PIN_FAIL 11
`define ECP_PIN_RESET 12'h003

`endif

/* rtl/ecp_pkg.sv */
package ecp_pkg;
   `include "ecp_defs.svh"

   typedef enum logic [1:0] {
      ECP_JUDGE_NONE,
      ECP_JUDGE_HIGH,
      ECP_JUDGE_IN,
      ECP_JUDGE_LOW
   } ecp_judge_e;

   typedef logic [`ECP_EVT_WIDTH-1:0] ecp_evt_t;
   typedef logic [`ECP_PIN_WIDTH-1:0] ecp_pin_t;
   typedef logic [`ECP_IN_WIDTH-1:0] ecp_in_t;

   typedef struct packed {
      logic sinkMode;
      ecp_evt_t event_;
      ecp_evt_t mask;
      logic measBusy;
      logic ccBusy;
      logic vcBusy;
      logic opBusy;
      logic valid;
      ecp_judge_e judge;
      ecp_pin_t on;
      ecp_pin_t pins;
      logic [31:0] rdata;
   } ecp_state_s;
endpackage

/* rtl/ecp_input_sync.sv */
`timescale 1ns/10ps
module ecp_input_sync (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Raw inputs and results
   input wire ecp_pkg::ecp_in_t rawIn,
   output ecp_pkg::ecp_in_t level,
   output ecp_pkg::ecp_in_t rise
);
   import ecp_pkg::*;

   typedef struct packed {
      ecp_in_t meta;
      ecp_in_t sync;
      ecp_in_t last;
   } ecp_sync_s;

   ecp_sync_s state;
   ecp_sync_s next_state;

   // Two-stage synchroniser, edge found between stage two and a delayed copy
   always_comb begin
      next_state.meta = rawIn; // R18
      next_state.sync = state.meta; // R18
      next_state.last = state.sync;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign level = state.sync;
   assign rise = state.sync & ~state.last; // R18
endmodule // ecp_input_sync

/* rtl/ecp_port.sv */
// The address map and the APB register port were decided locally.
`timescale 1ns/10ps
module ecp_port (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Interrupt to the instrument processor
   output logic irq,
   // Command inputs from the controller, on-state high
   input wire logic measureTrigger,
   input wire logic contactCheckReq,
   input wire logic voltageCheckReq,
   input wire logic openCorrectReq,
   input wire logic voltageStartReq,
   input wire logic voltageStopReq,
   input wire logic clearReq,
   input wire logic interlockReq,
   input wire logic panelLockInput,
   // Status pins to the controller, electrical level
   output logic measurementDone,
   output logic acquisitionDone,
   output logic measureFault,
   output logic contactCheckPass,
   output logic voltageCheckPass,
   output logic openCorrectPass,
   output logic voltageActive,
   output logic judgeHigh,
   output logic judgeIn,
   output logic judgeLow,
   output logic judgePass,
   output logic judgeFail,
   // Internal instrument controls
   output logic driveVoltage,
   output logic interlockBypass,
   output logic keysLocked
);
   import ecp_pkg::*;

   ecp_state_s state;
   ecp_state_s next_state;
   ecp_in_t rawIn;
   ecp_in_t inLevel;
   ecp_in_t inRise;

   logic setupRead;
   logic accessWrite;
   logic mapped;
   logic [7:0] addrWord;

   function automatic logic isMapped(input logic [7:0] a);
      isMapped = (a == `ECP_OFS_CTRL) || (a == `ECP_OFS_STATUS) || (a == `ECP_OFS_EVENT) ||
         (a == `ECP_OFS_MASK) || (a == `ECP_OFS_ACQ) || (a == `ECP_OFS_MEAS) ||
         (a == `ECP_OFS_CHECK) || (a == `ECP_OFS_PINS);
   endfunction

   function automatic logic isWrite(input logic [7:0] a, input logic [7:0] ofs, input logic hit);
      isWrite = hit && (a == ofs);
   endfunction

   assign rawIn = {panelLockInput, interlockReq, clearReq, voltageStopReq, voltageStartReq,
      openCorrectReq, voltageCheckReq, contactCheckReq, measureTrigger};

   ecp_input_sync u_sync (
      .clock(clock),
      .rst_n(rst_n),
      .rawIn(rawIn),
      .level(inLevel),
      .rise(inRise)
   );

   // APB decode: zero wait states, read data captured in the setup cycle
   assign addrWord = {paddr[7:2], 2'b00};
   assign mapped = isMapped(addrWord) && (paddr[1:0] == 2'b00);
   assign setupRead = psel && !penable && !pwrite;
   assign accessWrite = psel && penable && pwrite && mapped;
   assign pready = psel && penable;
   assign pslverr = psel && penable && !mapped;
   assign prdata = state.rdata;

   always_comb begin
      logic [31:0] rd;
      ecp_evt_t raised;
      ecp_evt_t w1c;
      logic wAcq;
      logic wMeas;
      logic wChk;
      logic [1:0] jcode;
      rd = 32'h0;
      raised = inRise[`ECP_EVT_WIDTH-1:0];
      w1c = '0;
      wAcq = isWrite(addrWord, `ECP_OFS_ACQ, accessWrite);
      wMeas = isWrite(addrWord, `ECP_OFS_MEAS, accessWrite);
      wChk = isWrite(addrWord, `ECP_OFS_CHECK, accessWrite);
      jcode = pwdata[`ECP_MEAS_JUDGE_MSB:`ECP_MEAS_JUDGE_LSB];
      next_state = state;

      // Software registers
      if (isWrite(addrWord, `ECP_OFS_CTRL, accessWrite)) begin
         next_state.sinkMode = pwdata[`ECP_CTRL_SINK];
      end
      if (isWrite(addrWord, `ECP_OFS_MASK, accessWrite)) begin
         next_state.mask = pwdata[`ECP_EVT_WIDTH-1:0];
      end
      if (isWrite(addrWord, `ECP_OFS_EVENT, accessWrite)) begin
         w1c = pwdata[`ECP_EVT_WIDTH-1:0];
      end
      // A new edge in the clearing cycle survives
      next_state.event_ = (state.event_ & ~w1c) | raised;

      // Measurement trigger drops the done levels until results arrive
      if (inRise[`ECP_EVT_MEASURE]) begin
         next_state.measBusy = 1'b1; // R01
         next_state.on[`ECP_PIN_DONE] = 1'b0; // R01
         next_state.on[`ECP_PIN_ACQ] = 1'b0; // R01
      end
      if (wAcq && pwdata[0]) begin
         next_state.on[`ECP_PIN_ACQ] = 1'b1; // R14
      end
      if (wMeas) begin
         next_state.measBusy = 1'b0;
         next_state.valid = 1'b1;
         next_state.judge = ecp_judge_e'(jcode);
         next_state.on[`ECP_PIN_DONE] = 1'b1; // R14
         next_state.on[`ECP_PIN_ACQ] = 1'b1; // R14
         next_state.on[`ECP_PIN_FAULT] = pwdata[`ECP_MEAS_OVERFLOW]; // R15
         next_state.on[`ECP_PIN_HIGH] = (jcode == `ECP_JUDGE_HIGH); // R12
         next_state.on[`ECP_PIN_IN] = (jcode == `ECP_JUDGE_IN); // R12
         next_state.on[`ECP_PIN_LOW] = (jcode == `ECP_JUDGE_LOW); // R12
         next_state.on[`ECP_PIN_PASS] = !pwdata[`ECP_MEAS_OVERFLOW] && (jcode == `ECP_JUDGE_IN); // R16
         next_state.on[`ECP_PIN_FAIL] = !pwdata[`ECP_MEAS_OVERFLOW] && (jcode != `ECP_JUDGE_IN); // R16
      end

      // Contact check
      if (inRise[`ECP_EVT_CCHK]) begin
         next_state.ccBusy = 1'b1; // R02
         next_state.on[`ECP_PIN_CCPASS] = 1'b0; // R02
      end
      if (wChk && pwdata[`ECP_CHK_CC_DONE]) begin
         next_state.ccBusy = 1'b0;
         next_state.on[`ECP_PIN_CCPASS] = pwdata[`ECP_CHK_CC_PASS] && !pwdata[`ECP_CHK_CC_OVER]; // R02
         next_state.on[`ECP_PIN_FAULT] = pwdata[`ECP_CHK_CC_OVER]; // R15
      end

      // Voltage error check
      if (inRise[`ECP_EVT_VCHK]) begin
         next_state.vcBusy = 1'b1; // R03
      end
      if (wChk && pwdata[`ECP_CHK_VC_DONE]) begin
         next_state.vcBusy = 1'b0;
         next_state.on[`ECP_PIN_VCPASS] = pwdata[`ECP_CHK_VC_PASS]; // R13
      end

      // Open correction
      if (inRise[`ECP_EVT_OPEN]) begin
         next_state.opBusy = 1'b1; // R04
         next_state.on[`ECP_PIN_OPPASS] = 1'b0; // R04
      end
      if (wChk && pwdata[`ECP_CHK_OP_DONE]) begin
         next_state.opBusy = 1'b0;
         next_state.on[`ECP_PIN_OPPASS] = pwdata[`ECP_CHK_OP_PASS] && !pwdata[`ECP_CHK_OP_OVER]; // R04
         next_state.on[`ECP_PIN_FAULT] = pwdata[`ECP_CHK_OP_OVER]; // R15
      end

      // Voltage output; stop wins when both edges coincide
      if (inRise[`ECP_EVT_START]) begin
         next_state.on[`ECP_PIN_VACT] = 1'b1; // R05
      end
      if (inRise[`ECP_EVT_STOP]) begin
         next_state.on[`ECP_PIN_VACT] = 1'b0; // R06
      end

      // Clear erases value and judgment
      if (inRise[`ECP_EVT_CLEAR]) begin
         next_state.valid = 1'b0; // R07
         next_state.judge = ECP_JUDGE_NONE; // R07
         next_state.on[`ECP_PIN_HIGH] = 1'b0; // R07
         next_state.on[`ECP_PIN_IN] = 1'b0; // R07
         next_state.on[`ECP_PIN_LOW] = 1'b0; // R07
         next_state.on[`ECP_PIN_PASS] = 1'b0; // R07
         next_state.on[`ECP_PIN_FAIL] = 1'b0; // R07
      end

      // Pin levels: source mode drives on as high, sink mode inverts
      next_state.pins = next_state.on ^ {`ECP_PIN_WIDTH{next_state.sinkMode}}; // R17

      // Read data for the access phase
      unique case (addrWord)
         `ECP_OFS_CTRL: rd[`ECP_CTRL_SINK] = state.sinkMode;
         `ECP_OFS_STATUS: begin
            rd[`ECP_ST_INTERLOCK] = inLevel[`ECP_IN_INTERLOCK];
            rd[`ECP_ST_PANEL] = inLevel[`ECP_IN_PANEL];
            rd[`ECP_ST_MEAS_BUSY] = state.measBusy;
            rd[`ECP_ST_CC_BUSY] = state.ccBusy;
            rd[`ECP_ST_VC_BUSY] = state.vcBusy;
            rd[`ECP_ST_OP_BUSY] = state.opBusy;
            rd[`ECP_ST_VALID] = state.valid;
         end
         `ECP_OFS_EVENT: rd[`ECP_EVT_WIDTH-1:0] = state.event_;
         `ECP_OFS_MASK: rd[`ECP_EVT_WIDTH-1:0] = state.mask;
         `ECP_OFS_ACQ: rd[0] = state.on[`ECP_PIN_ACQ];
         `ECP_OFS_MEAS: rd[`ECP_MEAS_JUDGE_MSB:`ECP_MEAS_JUDGE_LSB] = state.judge;
         `ECP_OFS_PINS: rd[`ECP_PIN_WIDTH-1:0] = state.on;
         default: rd = 32'h0;
      endcase
      if (setupRead) begin
         next_state.rdata = rd;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= '0;
         state.sinkMode <= `ECP_CTRL_RESET;
         state.mask <= `ECP_MASK_RESET;
         state.on <= `ECP_PIN_RESET; // R10
         state.pins <= `ECP_PIN_RESET; // R10
      end else begin
         state <= next_state;
      end
   end

   assign irq = |(state.event_ & state.mask);

   assign measurementDone = state.pins[`ECP_PIN_DONE];
   assign acquisitionDone = state.pins[`ECP_PIN_ACQ];
   assign measureFault = state.pins[`ECP_PIN_FAULT];
   assign contactCheckPass = state.pins[`ECP_PIN_CCPASS];
   assign voltageCheckPass = state.pins[`ECP_PIN_VCPASS];
   assign openCorrectPass = state.pins[`ECP_PIN_OPPASS];
   assign voltageActive = state.pins[`ECP_PIN_VACT];
   assign judgeHigh = state.pins[`ECP_PIN_HIGH];
   assign judgeIn = state.pins[`ECP_PIN_IN];
   assign judgeLow = state.pins[`ECP_PIN_LOW];
   assign judgePass = state.pins[`ECP_PIN_PASS];
   assign judgeFail = state.pins[`ECP_PIN_FAIL];

   assign driveVoltage = state.on[`ECP_PIN_VACT]; // R05
   assign interlockBypass = inLevel[`ECP_IN_INTERLOCK]; // R08
   assign keysLocked = inLevel[`ECP_IN_PANEL]; // R09
endmodule // ecp_port

/* bench/ecp_port_checker.sv */
`timescale 1ns/10ps
module ecp_port_checker (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   // Controller lines
   input wire logic measureTrigger,
   input wire logic voltageStartReq,
   input wire logic voltageStopReq,
   input wire logic clearReq,
   input wire logic interlockReq,
   // Results
   input wire logic measurementDone,
   input wire logic acquisitionDone,
   input wire logic judgePass,
   input wire logic judgeFail,
   input wire logic driveVoltage,
   input wire logic interlockBypass
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   a_ready_access: assert property (psel && penable |-> pready)
      else $error("no pready");
   a_ready_idle: assert property (!penable |-> !pready)
      else $error("early pready");
   a_err_access: assert property (pslverr |-> psel && penable)
      else $error("stray pslverr");
   // Two sync flops, state set on the third edge
   a_start_late: assert property ($rose(voltageStartReq) && !driveVoltage |-> ##2 !driveVoltage)
      else $error("voltage on too soon");
   a_start_drives: assert property ($rose(voltageStartReq) ##0 !voltageStopReq [*4] |-> driveVoltage)
      else $error("voltage not on");
   a_stop_drops: assert property ($rose(voltageStopReq) |-> ##3 !driveVoltage)
      else $error("voltage not off");
   a_trigger_done: assert property ($rose(measureTrigger) |-> ##3 measurementDone == acquisitionDone)
      else $error("done pins split");
   a_clear_verdict: assert property ($rose(clearReq) |-> ##3 judgePass == judgeFail)
      else $error("verdict kept");
   a_interlock_level: assert property (interlockReq [*4] |-> interlockBypass)
      else $error("interlock ignored");
   c_voltage: cover property ($rose(driveVoltage));
   c_refused: cover property (pslverr);
   c_measure: cover property ($fell(measurementDone));
endmodule // ecp_port_checker

bind ecp_port ecp_port_checker u_ecp_port_checker (.clock, .rst_n, .psel, .penable, .pready, .pslverr,
   .measureTrigger, .voltageStartReq, .voltageStopReq, .clearReq, .interlockReq, .measurementDone,
   .acquisitionDone, .judgePass, .judgeFail, .driveVoltage, .interlockBypass);

/* bench/ecp_plc_model.sv */
`timescale 1ns/10ps
module ecp_plc_model (
   // Clock
   input wire logic clock,
   // Verdict pins
   input wire logic judgePass,
   input wire logic judgeFail,
   // Command lines, on-state high
   output ecp_pkg::ecp_in_t cmdLines
);
   import ecp_pkg::*;
   initial cmdLines = '0;
   // Trailing low cycles let the next edge be seen
   task automatic pulse(input int idx, input int width);
      cmdLines[idx] <= 1'b1;
      repeat (width) @(posedge clock);
      cmdLines[idx] <= 1'b0;
      repeat (2) @(posedge clock);
   endtask
   task automatic level(input int idx, input logic on);
      cmdLines[idx] <= on;
      repeat (4) @(posedge clock);
   endtask
   function automatic logic [1:0] verdict();
      return {judgePass, judgeFail};
   endfunction
endmodule // ecp_plc_model

/* bench/test_ecp_port.sv */
`timescale 1ns/10ps
module test_ecp_port;
   import ecp_pkg::*;
   `include "ecp_defs.svh"
   logic clock, rst_n, psel, penable, pwrite, pready, pslverr, irq, err;
   logic driveVoltage, interlockBypass, keysLocked;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   ecp_in_t cmd;
   ecp_pin_t pins;
   int errors, numChecks;

   ecp_port u_ecp_port (.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .irq, .measureTrigger(cmd[0]), .contactCheckReq(cmd[1]), .voltageCheckReq(cmd[2]),
      .openCorrectReq(cmd[3]), .voltageStartReq(cmd[4]), .voltageStopReq(cmd[5]), .clearReq(cmd[6]),
      .interlockReq(cmd[7]), .panelLockInput(cmd[8]), .measurementDone(pins[0]),
      .acquisitionDone(pins[1]), .measureFault(pins[2]), .contactCheckPass(pins[3]),
      .voltageCheckPass(pins[4]), .openCorrectPass(pins[5]), .voltageActive(pins[6]),
      .judgeHigh(pins[7]), .judgeIn(pins[8]), .judgeLow(pins[9]), .judgePass(pins[10]),
      .judgeFail(pins[11]), .driveVoltage, .interlockBypass, .keysLocked);
   ecp_plc_model u_ecp_plc_model (.clock, .judgePass(pins[10]), .judgeFail(pins[11]), .cmdLines(cmd));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      numChecks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1 && ++n < 50);
      if (pready !== 1'b1) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, pready, 1'b1);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask

   task automatic testReset;
      check(pins, 32'h003);
      apb(1'b0, `ECP_OFS_PINS, 0);
      check(rd, 32'h003);
      check(err, 1'b0);
      apb(1'b0, 8'h20, 0);
      check(err, 1'b1);
      check(rd, 0);
      // Misaligned write to the control word is refused and ignored
      apb(1'b1, 8'h01, 1);
      check(err, 1'b1);
      check(pins, 32'h003);
      $display("reset test done");
   endtask

   task automatic testEvents;
      apb(1'b1, `ECP_OFS_MASK, 32'h7f);
      for (int i = 0; i < 7; i++) begin
         u_ecp_plc_model.pulse(i, 3);
         check(irq, 1'b1);
         apb(1'b0, `ECP_OFS_EVENT, 0);
         check(rd, 32'h1 << i);
         apb(1'b1, `ECP_OFS_EVENT, 32'h1 << i);
         check(irq, 1'b0);
      end
      apb(1'b1, `ECP_OFS_MASK, 0);
      u_ecp_plc_model.pulse(0, 3);
      check(irq, 1'b0);
      apb(1'b1, `ECP_OFS_EVENT, 32'h7f);
      $display("event test done");
   endtask

   task automatic testMeasure;
      u_ecp_plc_model.pulse(0, 3);
      check(pins[1:0], 2'b00);
      apb(1'b1, `ECP_OFS_ACQ, 1);
      check(pins[1:0], 2'b10);
      for (int j = 1; j < 4; j++) begin
         apb(1'b1, `ECP_OFS_MEAS, j);
         check(pins, {j != 2, j == 2, j == 3, j == 2, j == 1, 7'h03});
      end
      check(u_ecp_plc_model.verdict(), 2'b01);
      apb(1'b1, `ECP_OFS_MEAS, 32'h6);
      check(pins, 32'h107);
      apb(1'b1, `ECP_OFS_MEAS, 32'h2);
      check(pins, 32'h503);
      apb(1'b1, `ECP_OFS_CHECK, 32'h07);
      check(pins, 32'h507);
      u_ecp_plc_model.pulse(6, 3);
      check(pins, 32'h007);
      apb(1'b0, `ECP_OFS_STATUS, 0);
      check(rd[6], 1'b0);
      $display("measure test done");
   endtask

   task automatic testChecks;
      u_ecp_plc_model.pulse(1, 3);
      u_ecp_plc_model.pulse(2, 3);
      apb(1'b0, `ECP_OFS_STATUS, 0);
      check(rd[4:3], 2'b11);
      apb(1'b1, `ECP_OFS_CHECK, 32'h03);
      check(pins[3:2], 2'b10);
      apb(1'b1, `ECP_OFS_CHECK, 32'hc0);
      check(pins[4], 1'b1);
      u_ecp_plc_model.pulse(3, 3);
      apb(1'b1, `ECP_OFS_CHECK, 32'h38);
      check(pins[5:2], 4'b0111);
      $display("check test done");
   endtask

   task automatic testVoltage;
      u_ecp_plc_model.pulse(4, 3);
      check({driveVoltage, pins[6]}, 2'b11);
      apb(1'b1, `ECP_OFS_CTRL, 1);
      check(pins, 32'hfa0);
      u_ecp_plc_model.pulse(5, 3);
      check({driveVoltage, pins[6]}, 2'b01);
      apb(1'b1, `ECP_OFS_CTRL, 0);
      $display("voltage test done");
   endtask

   task automatic testLevels;
      u_ecp_plc_model.level(7, 1'b1);
      u_ecp_plc_model.level(8, 1'b1);
      apb(1'b0, `ECP_OFS_STATUS, 0);
      check({interlockBypass, keysLocked, rd[1:0]}, 4'hf);
      u_ecp_plc_model.level(7, 1'b0);
      u_ecp_plc_model.level(8, 1'b0);
      check({interlockBypass, keysLocked}, 2'b00);
      $display("level test done");
   endtask

   task automatic conclude;
      $display("checks %0d mismatches %0d", numChecks, errors);
      if (errors == 0 && numChecks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   initial begin
      {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      testReset;
      testEvents;
      testMeasure;
      testChecks;
      testVoltage;
      testLevels;
      conclude;
   end

   // Several times the few hundred cycles the tests need
   initial begin
      #60us;
      errors++;
      conclude;
   end
endmodule // test_ecp_port
